// File: lntw_bus_node.sv
// Model of the far-side bus node that shares the single-wire line
`timescale 1ns/1ps
`default_nettype none

module lntw_bus_node (
  input  wire logic master_low,    // Far node pulls the line dominant
  input  wire logic bus_drive_low, // Device pulls the line dominant
  output logic      bus_line       // Resulting line level, 1 recessive
);
  // ----------------------------------------------------------------
  // Wired-AND line
  // ----------------------------------------------------------------
  // The master pull-up holds the line recessive when both ends let go,
  // so a released line never shows a stale level
  assign bus_line = !(master_low || bus_drive_low);
endmodule // lntw_bus_node

`default_nettype wire

// File: lntw_link_ctrl.sv
// Control logic of a single-wire bus transceiver with wake and timeout
`timescale 1ns/1ps
`default_nettype none

module lntw_link_ctrl
  import lntw_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = DOM_TIMEOUT_CYC,
  parameter int unsigned WAKE_CYC    = BUS_WAKE_CYC,
  parameter int unsigned READY_CYC   = REG_READY_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic transmit_data_in,      // Pin; high recessive
  input  wire logic transmit_data_pulled,  // Pin is driven (0 means floating)
  input  wire logic bus_line_in,           // Sensed line level
  input  wire logic ignition_input,        // Pin
  input  wire logic wake_mode_select,      // 1 protocol, 0 edge
  input  wire logic transceiver_enable,    // Enable bit
  input  wire logic operating_mode_select, // 0 SPI, 1 standalone
  input  wire logic sleep_request,         // One-cycle go-to-sleep command
  output logic      bus_drive_low,         // Pull-down enable of line driver
  output logic      bus_pullup_strong,     // Normal pull-up; low means passive
  output logic      receive_data_out,
  output logic      awake,                 // Regulators and control running
  output logic      dominant_timeout       // Driver forced off by timeout
);

  localparam int TW = $clog2(TIMEOUT_CYC + 2);
  localparam int RW = $clog2(READY_CYC + 2);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] tx_s_r, txp_s_r, bus_s_r, ign_s_r;
  logic       ign_last_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_s_r     <= {2{BUS_RECESSIVE}};
      txp_s_r    <= 2'b00;
      bus_s_r    <= {2{BUS_RECESSIVE}};
      ign_s_r    <= 2'b00;
      ign_last_r <= 1'b0;
    end else begin
      tx_s_r     <= {tx_s_r[0], transmit_data_in};
      txp_s_r    <= {txp_s_r[0], transmit_data_pulled};
      bus_s_r    <= {bus_s_r[0], bus_line_in};
      ign_s_r    <= {ign_s_r[0], ignition_input};
      ign_last_r <= ign_s_r[1];
    end
  end

  logic tx_req, bus_lvl, ign_rise;
  // An undriven input counts as recessive, like a pull-up
  assign tx_req   = txp_s_r[1] ? tx_s_r[1] : BUS_RECESSIVE;
  assign bus_lvl  = bus_s_r[1];
  assign ign_rise = ign_s_r[1] && !ign_last_r;

  // ----------------------------------------------------------------
  // Wake filter, armed only in sleep; mode bit alone picks sequence
  // ----------------------------------------------------------------
  lntw_state_t state_r, state_nxt;
  logic        bus_wake;

  lntw_wake_filter #(
    .WAKE_CYC (WAKE_CYC)
  ) u_wake (
    .clk              (clk),
    .rstn             (rstn),
    .armed            (state_r == LNTW_SLEEP),
    .wake_mode_select (wake_mode_select),
    .bus_level        (bus_lvl),
    .wake_pulse       (bus_wake)
  );

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  logic [RW-1:0] rdy_cnt_r, rdy_cnt_nxt;

  always_comb begin
    state_nxt   = state_r;
    rdy_cnt_nxt = '0;
    case (state_r)
      LNTW_SLEEP: begin
        if (bus_wake || ign_rise)
          state_nxt = LNTW_POWERUP;
      end
      LNTW_POWERUP: begin
        rdy_cnt_nxt = rdy_cnt_r + RW'(1);
        if (rdy_cnt_r == RW'(READY_CYC))
          // Enable already set goes straight to active
          state_nxt = transceiver_enable ? LNTW_ACTIVE : LNTW_STANDBY;
      end
      LNTW_STANDBY: begin
        if (sleep_request)
          state_nxt = LNTW_SLEEP;
        else if (transceiver_enable)
          state_nxt = LNTW_ACTIVE;
      end
      LNTW_ACTIVE: begin
        if (sleep_request)
          state_nxt = LNTW_SLEEP;
        else if (!transceiver_enable)
          state_nxt = LNTW_STANDBY;
      end
      default: state_nxt = LNTW_SLEEP;
    endcase
  end

  // Power-on state is awake so the controller comes up with the chip
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r   <= LNTW_POWERUP;
      rdy_cnt_r <= '0;
    end else begin
      state_r   <= state_nxt;
      rdy_cnt_r <= rdy_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Dominant timeout
  // ----------------------------------------------------------------
  logic [TW-1:0] to_cnt_r, to_cnt_nxt;
  logic          to_hit_r, to_hit_nxt;
  logic          to_on;

  // Timer only runs in SPI mode with protocol wake and enable set
  assign to_on = (operating_mode_select == OP_SPI) &&
                 (wake_mode_select == WAKE_PROTOCOL) && transceiver_enable;

  always_comb begin
    to_cnt_nxt = to_cnt_r;
    to_hit_nxt = to_hit_r;
    if (state_r != LNTW_ACTIVE || !to_on || tx_req == BUS_RECESSIVE) begin
      // Recessive request restarts the period and clears the block
      to_cnt_nxt = '0;
      to_hit_nxt = 1'b0;
    end else if (to_cnt_r == TW'(TIMEOUT_CYC)) begin
      to_hit_nxt = 1'b1;
    end else begin
      to_cnt_nxt = to_cnt_r + TW'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      to_cnt_r <= '0;
      to_hit_r <= 1'b0;
    end else begin
      to_cnt_r <= to_cnt_nxt;
      to_hit_r <= to_hit_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic drv_nxt, pu_nxt, rx_nxt, awake_nxt;
  logic drv_r, pu_r, rx_r, awake_r, to_out_r;

  always_comb begin
    // Drive low only when active, requested dominant, not timed out
    drv_nxt   = (state_nxt == LNTW_ACTIVE) && (tx_req == BUS_DOMINANT) && !to_hit_nxt;
    // Passive line unless fully active: asleep in standby
    pu_nxt    = (state_nxt == LNTW_ACTIVE);
    // Receive mirrors the line when awake, low in sleep
    rx_nxt    = (state_nxt != LNTW_SLEEP) ? bus_lvl : 1'b0;
    awake_nxt = (state_nxt != LNTW_SLEEP);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drv_r    <= 1'b0;
      pu_r     <= 1'b0;
      rx_r     <= 1'b0;
      awake_r  <= 1'b0;
      to_out_r <= 1'b0;
    end else begin
      drv_r    <= drv_nxt;
      pu_r     <= pu_nxt;
      rx_r     <= rx_nxt;
      awake_r  <= awake_nxt;
      to_out_r <= to_hit_nxt;
    end
  end

  assign bus_drive_low     = drv_r;
  assign bus_pullup_strong = pu_r;
  assign receive_data_out  = rx_r;
  assign awake             = awake_r;
  assign dominant_timeout  = to_out_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_TIMEOUT_RELEASE: assert property (@(posedge clk) disable iff (!rstn)
    $rose(to_hit_r) |=> !drv_r)
    else $error("Driver not released after timeout");

  AST_TIMEOUT_GATED: assert property (@(posedge clk) disable iff (!rstn)
    !to_on |=> !to_hit_r)
    else $error("Timeout active while disabled");

  AST_TX_FOLLOW: assert property (@(posedge clk) disable iff (!rstn)
    (state_nxt == LNTW_ACTIVE && tx_req == BUS_DOMINANT && !to_hit_nxt) |=> drv_r)
    else $error("Dominant request not driven");

  AST_FLOAT_RECESSIVE: assert property (@(posedge clk) disable iff (!rstn)
    (!txp_s_r[1]) |=> !drv_r)
    else $error("Floating transmit drove the line");

  AST_RX_MIRROR: assert property (@(posedge clk) disable iff (!rstn)
    (state_nxt != LNTW_SLEEP) |=> (rx_r == $past(bus_lvl)))
    else $error("Receive output does not follow bus");

  AST_RX_SLEEP_LOW: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == LNTW_SLEEP) |-> (!rx_r && !drv_r))
    else $error("Receive or driver active in sleep");

  AST_SLEEP_PASSIVE: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == LNTW_SLEEP) |-> !pu_r)
    else $error("Line not passive in sleep");

  AST_STANDBY_IGNORE_TX: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == LNTW_STANDBY && state_nxt == LNTW_STANDBY) |=> !drv_r)
    else $error("Transmit not ignored in standby");

  AST_IGN_WAKE: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == LNTW_SLEEP && ign_rise) |=> (state_r == LNTW_POWERUP) ##1 awake_r)
    else $error("Ignition rise did not wake");

  AST_TO_RESTART: assert property (@(posedge clk) disable iff (!rstn)
    (tx_req == BUS_RECESSIVE) |=> (to_cnt_r == '0))
    else $error("Timeout counter not restarted");

endmodule : lntw_link_ctrl

`default_nettype wire

// File: lntw_link_ctrl_test.sv
// Self-checking bench for the bus transceiver control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("Error %s expected %b seen %b", nm, ex, got); end end

module lntw_link_ctrl_test import lntw_pkg::*; ;
  // Short counts keep the run brief; expectations derive from these
  localparam int unsigned TO_CYC = 20;
  localparam int unsigned WK_CYC = 8;
  logic clk, rstn, tx, tx_pulled, ign, wk_mode, en, op_mode, slp, master_low;
  logic line, drv, pup, rx, awk, dto;
  int   n_errors    = 0;
  int   check_count = 0;

  // ----------------------------------------------------------------
  // Design and far-side node
  // ----------------------------------------------------------------
  lntw_link_ctrl #(.TIMEOUT_CYC(TO_CYC), .WAKE_CYC(WK_CYC), .READY_CYC(4)) dut (
    .clk(clk), .rstn(rstn), .transmit_data_in(tx), .transmit_data_pulled(tx_pulled),
    .bus_line_in(line), .ignition_input(ign), .wake_mode_select(wk_mode),
    .transceiver_enable(en), .operating_mode_select(op_mode), .sleep_request(slp),
    .bus_drive_low(drv), .bus_pullup_strong(pup), .receive_data_out(rx),
    .awake(awk), .dominant_timeout(dto));
  lntw_bus_node node (.master_low(master_low), .bus_drive_low(drv), .bus_line(line));

  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Bounded wait, since wake latency depends on synchronisers
  task automatic wait_awake(input logic v);
    int k;
    k = 0;
    while (awk !== v && k < 40) begin
      cyc(1);
      k++;
    end
    `CHK("awake", v, awk)
  endtask

  task automatic go_sleep();
    slp = 1'b1;
    cyc(1);
    slp = 1'b0;
    cyc(2);
    `CHK("awake", 1'b0, awk)
    `CHK("rx", 1'b0, rx)
    `CHK("pullup", 1'b0, pup)
    `CHK("drive", 1'b0, drv)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_active();
    wait_awake(1'b1);
    cyc(10);
    `CHK("pullup", 1'b1, pup)
    // Receive lags transmit by six edges: three to the line, three back
    tx = 1'b0;
    cyc(7);
    `CHK("drive", 1'b1, drv)
    `CHK("rx", BUS_DOMINANT, rx)
    tx = 1'b1;
    cyc(7);
    `CHK("drive", 1'b0, drv)
    `CHK("rx", BUS_RECESSIVE, rx)
    tx_pulled = 1'b0;
    tx = 1'b0;
    cyc(5);
    `CHK("drive", 1'b0, drv)
    tx_pulled = 1'b1;
    tx = 1'b1;
    master_low = 1'b1;
    cyc(5);
    `CHK("rx", 1'b0, rx)
    master_low = 1'b0;
    cyc(5);
    $display("test active done");
  endtask

  task automatic t_timeout();
    tx = 1'b0;
    cyc(TO_CYC + 10);
    `CHK("timeout", 1'b1, dto)
    `CHK("drive", 1'b0, drv)
    tx = 1'b1;
    cyc(5);
    `CHK("timeout", 1'b0, dto)
    tx = 1'b0;
    cyc(TO_CYC - 5);
    `CHK("drive", 1'b1, drv)
    tx = 1'b1;
    cyc(5);
    // Standalone mode, then edge wake mode: no timeout in either
    for (int i = 0; i < 2; i++) begin
      op_mode = (i == 0) ? OP_STANDALONE : OP_SPI;
      wk_mode = (i == 0) ? WAKE_PROTOCOL : WAKE_EDGE;
      tx = 1'b0;
      cyc(TO_CYC + 10);
      `CHK("drive", 1'b1, drv)
      tx = 1'b1;
      cyc(5);
    end
    op_mode = OP_SPI;
    wk_mode = WAKE_PROTOCOL;
    $display("test timeout done");
  endtask

  task automatic t_wake_protocol();
    go_sleep();
    master_low = 1'b1;
    cyc(4);
    master_low = 1'b0;
    cyc(20);
    `CHK("awake", 1'b0, awk)
    master_low = 1'b1;
    cyc(WK_CYC + 10);
    `CHK("awake", 1'b0, awk)
    `CHK("rx", 1'b0, rx)
    master_low = 1'b0;
    wait_awake(1'b1);
    cyc(12);
    $display("test protocol wake done");
  endtask

  task automatic t_wake_edge();
    wk_mode = WAKE_EDGE;
    op_mode = OP_STANDALONE;
    go_sleep();
    // A line left steady since sleep entry is no wake request
    cyc(WK_CYC + 10);
    `CHK("awake", 1'b0, awk)
    // Changes shorter than the filter keep restarting it
    repeat (6) begin
      master_low = !master_low;
      cyc(4);
    end
    `CHK("awake", 1'b0, awk)
    master_low = 1'b1;
    wait_awake(1'b1);
    master_low = 1'b0;
    wk_mode = WAKE_PROTOCOL;
    op_mode = OP_SPI;
    cyc(12);
    $display("test edge wake done");
  endtask

  task automatic t_ign_standby();
    en = 1'b0;
    go_sleep();
    ign = 1'b1;
    wait_awake(1'b1);
    cyc(12);
    tx = 1'b0;
    cyc(5);
    `CHK("drive", 1'b0, drv)
    `CHK("pullup", 1'b0, pup)
    master_low = 1'b1;
    cyc(5);
    `CHK("rx", 1'b0, rx)
    master_low = 1'b0;
    en = 1'b1;
    cyc(5);
    `CHK("drive", 1'b1, drv)
    tx = 1'b1;
    ign = 1'b0;
    cyc(5);
    $display("test ignition standby done");
  endtask

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog: all scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    tx = 1'b1;
    tx_pulled = 1'b1;
    ign = 1'b0;
    wk_mode = WAKE_PROTOCOL;
    en = 1'b1;
    op_mode = OP_SPI;
    slp = 1'b0;
    master_low = 1'b0;
    cyc(3);
    rstn = 1'b1;
    t_active();
    t_timeout();
    t_wake_protocol();
    t_wake_edge();
    t_ign_standby();
    complete_run();
  end
endmodule // lntw_link_ctrl_test

`default_nettype wire

// File: lntw_pkg.sv
// Package of constants and types for the single-wire bus transceiver control block
package lntw_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ            = 40_000_000;
  // Dominant timeout, in microseconds
  localparam int unsigned DOM_TIMEOUT_US    = 12_000;
  localparam int unsigned DOM_TIMEOUT_CYC   = (DOM_TIMEOUT_US * (CLK_HZ / 1_000_000));
  // Bus wake filter time, in microseconds
  localparam int unsigned BUS_WAKE_US       = 80;
  localparam int unsigned BUS_WAKE_CYC      = (BUS_WAKE_US * (CLK_HZ / 1_000_000));
  // Regulator ready delay after wake, in microseconds
  localparam int unsigned REG_READY_US      = 10;
  localparam int unsigned REG_READY_CYC     = (REG_READY_US * (CLK_HZ / 1_000_000));

  // ----------------------------------------------------------------
  // Mode encodings
  // ----------------------------------------------------------------
  localparam logic OP_SPI         = 1'b0;
  localparam logic OP_STANDALONE  = 1'b1;
  localparam logic WAKE_EDGE      = 1'b0;
  localparam logic WAKE_PROTOCOL  = 1'b1;
  localparam logic BUS_DOMINANT   = 1'b0;
  localparam logic BUS_RECESSIVE  = 1'b1;

  // Power state of the link (one-hot)
  typedef enum logic [3:0] {
    LNTW_SLEEP   = 4'b0001,
    LNTW_POWERUP = 4'b0010,
    LNTW_STANDBY = 4'b0100,
    LNTW_ACTIVE  = 4'b1000
  } lntw_state_t;

endpackage : lntw_pkg

// File: lntw_wake_filter.sv
// Bus wake filter that qualifies wake requests while asleep
`timescale 1ns/1ps
`default_nettype none

module lntw_wake_filter
  import lntw_pkg::*;
#(
  parameter int unsigned WAKE_CYC = BUS_WAKE_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic armed,            // High while asleep
  input  wire logic wake_mode_select, // 1 protocol, 0 edge
  input  wire logic bus_level,        // Synchronised bus level
  output logic      wake_pulse        // One-cycle wake request
);

  localparam int CW = $clog2(WAKE_CYC + 2);

  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          last_r, last_nxt;
  logic          qual_r, qual_nxt;  // Current level held long enough
  logic          wake_r, wake_nxt;
  logic          seen_r, seen_nxt;  // A change was seen since arming
  logic [CW-1:0] run_r, run_nxt;    // Cycles the level has held, for the check

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    cnt_nxt  = cnt_r;
    last_nxt = bus_level;
    qual_nxt = qual_r;
    wake_nxt = 1'b0;
    seen_nxt = seen_r;
    // Check counter runs free of arming and of the filter's own state
    if (bus_level != last_r)
      run_nxt = '0;
    else if (run_r == CW'(WAKE_CYC))
      run_nxt = run_r;
    else
      run_nxt = run_r + CW'(1);
    if (!armed) begin
      cnt_nxt  = '0;
      qual_nxt = 1'b0;
      seen_nxt = 1'b0;
    end else if (bus_level != last_r) begin
      // Any change restarts the filter
      cnt_nxt  = '0;
      qual_nxt = 1'b0;
      seen_nxt = 1'b1;
      // Protocol wake fires on rise after qualified dominant
      if (wake_mode_select == WAKE_PROTOCOL && qual_r && bus_level == BUS_RECESSIVE)
        wake_nxt = 1'b1;
    end else if (!qual_r) begin
      if (cnt_r == CW'(WAKE_CYC)) begin
        qual_nxt = 1'b1;
        // Edge wake needs a real change, not a line left steady since sleep
        if (wake_mode_select == WAKE_EDGE && seen_r)
          wake_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + CW'(1);
      end
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r  <= '0;
      last_r <= BUS_RECESSIVE;
      qual_r <= 1'b0;
      wake_r <= 1'b0;
      seen_r <= 1'b0;
      run_r  <= '0;
    end else begin
      cnt_r  <= cnt_nxt;
      last_r <= last_nxt;
      qual_r <= qual_nxt;
      wake_r <= wake_nxt;
      seen_r <= seen_nxt;
      run_r  <= run_nxt;
    end
  end

  assign wake_pulse = wake_r;

  // Edge mode wakes only on a level held for the full filter time
  AST_EDGE_HELD: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(wake_r) && $past(wake_mode_select) == WAKE_EDGE) |->
      ($past(run_r) == CW'(WAKE_CYC)))
    else $error("Edge wake without a held level");

endmodule : lntw_wake_filter

`default_nettype wire
